/* File: rtl/dtx_burst_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module dtx_burst_timer #(
    parameter int unsigned CNT_W = 25
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             start_in,
    input  wire logic             abort_in,
    input  wire logic [CNT_W-1:0] length_in,
    output logic                  busy_out,
    output logic                  done_out
);
    initial
    begin
        if (CNT_W < 2)
            $error("dtx_burst_timer: counter too narrow");
    end

    logic [CNT_W-1:0] count;
    wire              last = busy_out && (count <= 1);

    // Down counter, one-cycle done pulse at expiry
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count    <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= last && !abort_in;
            if (abort_in || last)
                busy_out <= 1'b0;
            else if (start_in && !busy_out)
            begin
                busy_out <= 1'b1;
                count    <= length_in;
            end
            else if (busy_out)
                count <= count - 1'b1;
        end
    end
endmodule : dtx_burst_timer
`default_nettype wire

/* File: rtl/dtx_ctrl_status.sv */
// How it works
// - Control B bit 0 low enables burst transmit, high disables it.
// - Each burst-mode digit write gives one tone burst then an equal pause.
// - At pause end, status bit 1 shows transmitter empty; interrupt if enabled.
// - Call-progress mode doubles burst and pause to 102 ms each.
// - Without burst, tone lasts while tone-output-enable stays set; untimed.
// - Control B bit 1 high puts both receivers to sleep.
// - Control B bit 2 high gives single tone, low dual tone.
// - Control B bit 3 picks column or row tone in single-tone mode.
// - Transmitter and receivers both asleep also stops oscillator and reference.
// - Status bit 0 sets with bit 1 or 2; cleared by status read.
// - Status bit 1 sets at pause end in burst; clears on read or non-burst.
// - Status bit 2 sets on received digit load; clears on status read.
// - Status bit 3 sets on valid tone absence, clears on valid tone.
// - Select line and direction pick transmit, receive, control or status.
// - Control A bit 3 steers next control write to B, then back.
// - Interrupt pin goes low on digit or burst ready in tone-dialing mode.
// - Clearing tone-output-enable sleeps transmitter, floats tone, clears transmit data.
`timescale 1ns/1ps
`default_nettype none
module dtx_ctrl_status #(
    parameter int unsigned BURST_CYCLES    = dtx_pkg::BURST_CYCLES,
    parameter int unsigned BURST_CP_CYCLES = dtx_pkg::BURST_CP_CYCLES,
    parameter int unsigned FIFO_DEPTH      = 8
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // Host register port: one access per strobe
    input  wire logic       access_in,
    input  wire logic       register_select_line_in,
    input  wire logic       read_in,
    input  wire logic [3:0] wdata_in,
    output logic      [3:0] rdata_out,
    output logic            rdata_valid_out,
    // Receiver side events
    input  wire logic       rx_digit_valid_in,
    input  wire logic [3:0] rx_digit_in,
    input  wire logic       rx_tone_present_in,
    input  wire logic       rx_tone_absent_in,
    input  wire logic       call_progress_wave_in,
    // Transmitter and power controls
    output logic            tone_active_out,
    output logic      [3:0] tone_digit_out,
    output logic            tone_single_out,
    output logic            tone_column_out,
    output logic            tone_output_enable_out,
    output logic            tone_pin_oe_b_out,
    output logic            receiver_sleep_out,
    output logic            osc_sleep_out,
    output logic            tx_data_ready_out,
    // Open-drain interrupt pin: drive low when enable low
    output logic            interrupt_or_progress_pin_out,
    output logic            interrupt_or_progress_pin_oe_b_out
);
    localparam int unsigned CNT_W = $clog2(BURST_CP_CYCLES + 1);

    initial
    begin
        if (BURST_CYCLES < 1 || BURST_CP_CYCLES < BURST_CYCLES)
            $error("dtx_ctrl_status: bad burst lengths");
    end

    logic [3:0]          control_a;
    logic [3:0]          control_b;
    logic [3:0]          transceiver_status;
    logic [3:0]          rx_data;
    logic                second_control_select;
    dtx_pkg::dtx_phase_t phase;
    dtx_pkg::dtx_phase_t next_phase;

    // Register decode
    wire wr_tx     = access_in && !register_select_line_in && !read_in;
    wire rd_rx     = access_in && !register_select_line_in && read_in;
    wire wr_ctrl   = access_in && register_select_line_in && !read_in;
    wire rd_status = access_in && register_select_line_in && read_in;
    wire wr_ctl_a  = wr_ctrl && !second_control_select;
    wire wr_ctl_b  = wr_ctrl && second_control_select;

    // Control fields
    wire tone_output_enable = control_a[dtx_pkg::CA_TONE_OUT_BIT];
    wire call_progress_select = control_a[dtx_pkg::CA_CALL_PROG_BIT];
    wire irq_enable = control_a[dtx_pkg::CA_IRQ_EN_BIT];
    wire burst_on = !control_b[dtx_pkg::CB_BURST_OFF_BIT];
    wire receiver_sleep = control_b[dtx_pkg::CB_RX_SLEEP_BIT];

    // Transmit data path: digit writes queue while a burst runs
    logic       q_valid;
    logic       q_ready;
    logic [3:0] q_data;
    logic       fifo_in_ready;
    logic       t_busy;
    logic       t_done;
    logic       t_start;
    logic [3:0] tx_digit;

    // A disabled tone output drops any queued digits
    wire tx_flush = !tone_output_enable;

    dtx_fifo #(
        .WIDTH (4),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .flush_in      (tx_flush),
        .in_valid_in   (wr_tx && tone_output_enable),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (wdata_in),
        .out_valid_out (q_valid),
        .out_ready_in  (q_ready),
        .out_data_out  (q_data)
    );

    // Burst and pause lengths; call progress doubles them
    wire [CNT_W-1:0] burst_len = call_progress_select ? CNT_W'(BURST_CP_CYCLES)
                                                      : CNT_W'(BURST_CYCLES);

    dtx_burst_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .start_in    (t_start),
        .abort_in    (tx_flush || !burst_on),
        .length_in   (burst_len),
        .busy_out    (t_busy),
        .done_out    (t_done)
    );

    // Phase sequencing: tone then equal pause in burst mode
    wire take_digit = (phase == dtx_pkg::DTX_IDLE) && q_valid;
    assign q_ready  = take_digit;
    assign t_start  = take_digit || ((phase == dtx_pkg::DTX_TONE) && t_done);
    wire pause_end  = (phase == dtx_pkg::DTX_PAUSE) && t_done;

    always_comb
    begin
        next_phase = phase;
        case (phase)
            dtx_pkg::DTX_IDLE:
                if (take_digit)
                    next_phase = dtx_pkg::DTX_TONE;
            dtx_pkg::DTX_TONE:
                if (t_done)
                    next_phase = dtx_pkg::DTX_PAUSE;
            dtx_pkg::DTX_PAUSE:
                if (t_done)
                    next_phase = dtx_pkg::DTX_IDLE;
            default:
                next_phase = dtx_pkg::DTX_IDLE;
        endcase
        if (!burst_on || tx_flush)
            next_phase = dtx_pkg::DTX_IDLE;
    end

    // Phase register and the digit being sent
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            phase    <= dtx_pkg::DTX_IDLE;
            tx_digit <= 4'h0;
        end
        else
        begin
            phase <= next_phase;
            if (tx_flush)
                tx_digit <= 4'h0;
            else if (take_digit && burst_on)
                tx_digit <= q_data;
            else if (wr_tx && !burst_on)
                tx_digit <= wdata_in;
        end
    end

    // Control writes and the B pointer; no reset pin on the part, the host sequence settles it
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            control_a             <= dtx_pkg::CTRL_A_RESET;
            control_b             <= dtx_pkg::CTRL_B_RESET;
            second_control_select <= 1'b0;
        end
        else if (wr_ctl_a)
        begin
            control_a             <= wdata_in;
            second_control_select <= wdata_in[dtx_pkg::CA_SEL_B_BIT];
        end
        else if (wr_ctl_b)
        begin
            control_b             <= wdata_in;
            second_control_select <= 1'b0;
        end
    end

    // Status flags: hardware set beats the read clear
    wire tx_empty_set = pause_end && burst_on;
    wire rx_full_set  = rx_digit_valid_in && !receiver_sleep
                        && !call_progress_select;
    wire next_tx_empty = tx_empty_set
                         || (transceiver_status[dtx_pkg::ST_TX_EMPTY_BIT] && !rd_status && burst_on);
    wire next_rx_full = rx_full_set
                        || (transceiver_status[dtx_pkg::ST_RX_FULL_BIT] && !rd_status);
    wire next_irq = tx_empty_set || rx_full_set
                    || (transceiver_status[dtx_pkg::ST_IRQ_BIT] && !rd_status);
    wire next_delay = rx_tone_absent_in
                      || (transceiver_status[dtx_pkg::ST_DELAY_STR_BIT] && !rx_tone_present_in);

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            transceiver_status <= dtx_pkg::STATUS_RESET;
            rx_data            <= 4'h0;
        end
        else
        begin
            transceiver_status <= {next_delay, next_rx_full, next_tx_empty, next_irq};
            if (rx_full_set)
                rx_data <= rx_digit_in;
        end
    end

    // Read data: registered answer one cycle after the strobe
    wire [3:0] read_mux = rd_status ? transceiver_status : rx_data;

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rdata_out       <= 4'h0;
            rdata_valid_out <= 1'b0;
        end
        else
        begin
            rdata_valid_out <= rd_status || rd_rx;
            if (rd_status || rd_rx)
                rdata_out <= read_mux;
        end
    end

    // Tone output: burst mode times it, otherwise tone_output_enable alone
    wire tone_on = tone_output_enable
                   && (burst_on ? (phase == dtx_pkg::DTX_TONE) : 1'b1);
    wire osc_off = !tone_output_enable && receiver_sleep;

    // Interrupt pin: sink while an enabled event is pending, or follow the
    // call-progress wave; pin only pulls low so a high wave means release
    wire irq_pending = transceiver_status[dtx_pkg::ST_TX_EMPTY_BIT]
                       || transceiver_status[dtx_pkg::ST_RX_FULL_BIT];
    wire pin_sink = irq_enable && (call_progress_select ? !call_progress_wave_in
                                                        : irq_pending);

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tone_active_out                    <= 1'b0;
            tone_digit_out                     <= 4'h0;
            tone_single_out                    <= 1'b0;
            tone_column_out                    <= 1'b0;
            tone_output_enable_out             <= 1'b0;
            tone_pin_oe_b_out                  <= 1'b1;
            receiver_sleep_out                 <= 1'b0;
            osc_sleep_out                      <= 1'b0;
            tx_data_ready_out                  <= 1'b0;
            interrupt_or_progress_pin_out      <= 1'b0;
            interrupt_or_progress_pin_oe_b_out <= 1'b1;
        end
        else
        begin
            tone_active_out                    <= tone_on;
            tone_digit_out                     <= tx_digit;
            tone_single_out                    <= control_b[dtx_pkg::CB_SINGLE_BIT];
            tone_column_out                    <= control_b[dtx_pkg::CB_COLUMN_BIT];
            tone_output_enable_out             <= tone_output_enable;
            tone_pin_oe_b_out                  <= !tone_output_enable;
            receiver_sleep_out                 <= receiver_sleep;
            osc_sleep_out                      <= osc_off;
            tx_data_ready_out                  <= fifo_in_ready;
            interrupt_or_progress_pin_out      <= 1'b0;
            interrupt_or_progress_pin_oe_b_out <= !pin_sink;
        end
    end
endmodule : dtx_ctrl_status
`default_nettype wire

/* File: rtl/dtx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dtx_fifo #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("dtx_fifo: depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = in_valid_in && !full;
    wire              pop   = out_ready_in && !empty;

    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem[rd_ptr[AW-1:0]];

    // Storage has no reset; only pointers define contents
    always_ff @(posedge core_clk_in)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data_in;
    end

    // Pointers, flush drops everything queued
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (flush_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : dtx_fifo
`default_nettype wire

/* File: rtl/dtx_pkg.sv */
package dtx_pkg;
    // Control register A field positions
    localparam int unsigned CA_TONE_OUT_BIT  = 0;
    localparam int unsigned CA_CALL_PROG_BIT = 1;
    localparam int unsigned CA_IRQ_EN_BIT    = 2;
    localparam int unsigned CA_SEL_B_BIT     = 3;
    // Control register B field positions
    localparam int unsigned CB_BURST_OFF_BIT = 0;
    localparam int unsigned CB_RX_SLEEP_BIT  = 1;
    localparam int unsigned CB_SINGLE_BIT    = 2;
    localparam int unsigned CB_COLUMN_BIT    = 3;
    // Status register field positions
    localparam int unsigned ST_IRQ_BIT       = 0;
    localparam int unsigned ST_TX_EMPTY_BIT  = 1;
    localparam int unsigned ST_RX_FULL_BIT   = 2;
    localparam int unsigned ST_DELAY_STR_BIT = 3;
    // Values after reset
    localparam logic [3:0] CTRL_A_RESET = 4'h0;
    localparam logic [3:0] CTRL_B_RESET = 4'h0;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    // Burst timing
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned BURST_MS      = 51;
    localparam int unsigned BURST_CP_MS   = 102;
    localparam int unsigned BURST_CYCLES  = BURST_MS * CLK_MHZ * 1000;
    localparam int unsigned BURST_CP_CYCLES = BURST_CP_MS * CLK_MHZ * 1000;
    // Transmit phases
    typedef enum logic [1:0] {DTX_IDLE, DTX_TONE, DTX_PAUSE} dtx_phase_t;
endpackage : dtx_pkg

/* File: sim/dtx_ctrl_status_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dtx_ctrl_status_asserts (
    input wire logic       core_clk_in,
    input wire logic       rst_b_in,
    input wire logic       access_in,
    input wire logic       register_select_line_in,
    input wire logic       read_in,
    input wire logic [3:0] rdata_out,
    input wire logic       rdata_valid_out,
    input wire logic       tone_active_out,
    input wire logic       tone_single_out,
    input wire logic       tone_column_out,
    input wire logic       tone_output_enable_out,
    input wire logic       tone_pin_oe_b_out,
    input wire logic       receiver_sleep_out,
    input wire logic       osc_sleep_out
);
    default clocking dcb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Host access decode
    wire logic ctl_wr = access_in && register_select_line_in && !read_in;
    wire logic rd_acc = access_in && read_in;

    // Each read answered exactly once, one cycle later
    property p_read_answer;
        rd_acc |=> rdata_valid_out;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read access without answer");
    property p_no_stray;
        !rd_acc |=> !rdata_valid_out;
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("answer without read access");
    // Read data must not drift between answers
    property p_rdata_hold;
        !rdata_valid_out |-> $stable(rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without answer");
    // Oscillator sleeps only when both halves sleep
    property p_osc_sleep;
        osc_sleep_out == (!tone_output_enable_out && receiver_sleep_out);
    endproperty
    a_osc_sleep: assert property (p_osc_sleep)
        else $error("oscillator sleep wrong");
    property p_tone_float;
        tone_pin_oe_b_out == !tone_output_enable_out;
    endproperty
    a_tone_float: assert property (p_tone_float)
        else $error("tone pin drive wrong");
    // One cycle of grace after the enable falls
    property p_tone_off;
        !tone_output_enable_out && !$fell(tone_output_enable_out) |-> !tone_active_out;
    endproperty
    a_tone_off: assert property (p_tone_off)
        else $error("tone while output disabled");
    // Control fields reach the pins two edges after a control write, never otherwise
    property p_shape_hold;
        !ctl_wr |=> ##1 $stable({tone_single_out, tone_column_out, receiver_sleep_out});
    endproperty
    a_shape_hold: assert property (p_shape_hold)
        else $error("control B field changed without write");
    property p_enable_hold;
        !ctl_wr |=> ##1 $stable(tone_output_enable_out);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("tone enable changed without write");
endmodule : dtx_ctrl_status_asserts

bind dtx_ctrl_status dtx_ctrl_status_asserts u_dtx_ctrl_status_asserts (
    .core_clk_in, .rst_b_in, .access_in, .register_select_line_in, .read_in, .rdata_out,
    .rdata_valid_out, .tone_active_out, .tone_single_out, .tone_column_out,
    .tone_output_enable_out, .tone_pin_oe_b_out, .receiver_sleep_out, .osc_sleep_out
);
`default_nettype wire

/* File: sim/dtx_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dtx_host_model (
    input  wire logic       core_clk_in,
    output logic            access_out,
    output logic            sel_out,
    output logic            read_out,
    output logic      [3:0] wdata_out
);
    // Idle bus, data scrambled so no stale value is trusted
    initial
    begin
        access_out = 1'b0;
        sel_out    = 1'b1;
        read_out   = 1'b1;
        wdata_out  = 4'hA;
    end

    // One access held one cycle; random idle gap models slow and prompt hosts
    task automatic acc(input logic sel, input logic rd, input logic [3:0] wd);
        repeat ($urandom_range(1, 2)) @(posedge core_clk_in);
        access_out <= 1'b1;
        sel_out    <= sel;
        read_out   <= rd;
        wdata_out  <= wd;
        @(posedge core_clk_in);
        access_out <= 1'b0;
        wdata_out  <= ~wd;
    endtask : acc

    // Power-up initialisation, leaves control B and pointer cleared, control A holding 8 (bits 0 to 2 clear)
    task automatic soft_reset();
        acc(1'b1, 1'b1, 4'h0);
        acc(1'b1, 1'b0, 4'h0);
        acc(1'b1, 1'b0, 4'h0);
        acc(1'b1, 1'b0, 4'h8);
        acc(1'b1, 1'b0, 4'h0);
        acc(1'b1, 1'b1, 4'h0);
    endtask : soft_reset
endmodule : dtx_host_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk_in, rst_b_in, rx_digit_valid_in, rx_tone_present_in, rx_tone_absent_in;
    logic call_progress_wave_in, a0, tone_prev;
    logic [3:0] rx_digit_in, d;
    wire logic access_in, register_select_line_in, read_in, rdata_valid_out, tone_active_out;
    wire logic tone_single_out, tone_column_out, tone_output_enable_out, tone_pin_oe_b_out;
    wire logic receiver_sleep_out, osc_sleep_out, tx_data_ready_out, interrupt_or_progress_pin_oe_b_out;
    wire logic [3:0] wdata_in, rdata_out, tone_digit_out;
    logic [3:0] rd_q[$], tone_q[$];
    int len_q[$];
    int num_errors, comparisons, tone_len, exp_len, refused, seed;

    // Clock at 200 MHz
    initial
    begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    dtx_ctrl_status #(.BURST_CYCLES(20), .BURST_CP_CYCLES(40)) u_dtx_ctrl_status (
        .core_clk_in, .rst_b_in, .access_in, .register_select_line_in, .read_in, .wdata_in,
        .rdata_out, .rdata_valid_out, .rx_digit_valid_in, .rx_digit_in, .rx_tone_present_in,
        .rx_tone_absent_in, .call_progress_wave_in, .tone_active_out, .tone_digit_out,
        .tone_single_out, .tone_column_out, .tone_output_enable_out, .tone_pin_oe_b_out,
        .receiver_sleep_out, .osc_sleep_out, .tx_data_ready_out, .interrupt_or_progress_pin_out(),
        .interrupt_or_progress_pin_oe_b_out
    );
    dtx_host_model u_dtx_host_model (.core_clk_in, .access_out(access_in),
        .sel_out(register_select_line_in), .read_out(read_in), .wdata_out(wdata_in));

    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic sel, input logic [3:0] wd);
        u_dtx_host_model.acc(sel, 1'b0, wd);
    endtask : wr
    // Note the expected answer before the read goes out
    task automatic rd(input logic sel, input logic [3:0] exp);
        rd_q.push_back(exp);
        u_dtx_host_model.acc(sel, 1'b1, 4'h0);
    endtask : rd
    // One-cycle receiver event: 0 digit, 1 tone present, 2 tone absent
    task automatic pulse(input int which, input logic [3:0] dig);
        @(posedge core_clk_in);
        rx_digit_valid_in  <= (which == 0);
        rx_digit_in        <= dig;
        rx_tone_present_in <= (which == 1);
        rx_tone_absent_in  <= (which == 2);
        @(posedge core_clk_in);
        {rx_digit_valid_in, rx_tone_present_in, rx_tone_absent_in} <= 3'b000;
        repeat (2) @(posedge core_clk_in);
    endtask : pulse

    // Watchers sample at the falling edge, where registered outputs have settled
    always @(negedge core_clk_in)
    begin
        if (rdata_valid_out === 1'b1)
        begin
            if (rd_q.size() == 0) rd_q.push_back('x);
            check("read data", rd_q.pop_front(), rdata_out);
        end
        if (tone_active_out === 1'b1 && !tone_prev)
        begin
            tone_len = 0;
            if (tone_q.size() == 0) tone_q.push_back(4'h0); // Unnoted tone carries cleared transmit data
            check("tone digit", tone_q.pop_front(), tone_digit_out);
        end
        if (tone_active_out === 1'b1) tone_len++;
        if (tone_active_out !== 1'b1 && tone_prev && len_q.size() > 0)
        begin
            exp_len = len_q.pop_front();
            if (exp_len != 0) check("tone length", 4'h1, {3'h0, tone_len >= exp_len && tone_len <= exp_len + 2});
        end
        tone_prev = (tone_active_out === 1'b1);
    end

    // Rectified call-progress wave is noise to this block
    always @(posedge core_clk_in) call_progress_wave_in <= 1'($urandom_range(0, 1));

    // Bound is over thirty times the expected run
    initial
    begin
        #200000;
        num_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial
    begin
        seed = $urandom(32'hCF52);
        {rst_b_in, rx_digit_valid_in, rx_tone_present_in, rx_tone_absent_in} = 4'h0;
        rx_digit_in = 4'($urandom_range(0, 15));
        repeat (20) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        // Every control B value, random tone enable, then pointer back to A
        for (int i = 0; i < 16; i++)
        begin
            a0 = 1'($urandom_range(0, 1));
            wr(1'b1, {3'b100, a0});
            wr(1'b1, 4'(i));
            repeat (2) @(negedge core_clk_in);
            check("ctrl b", {i[3], i[2], i[1], i[1] & ~a0}, {tone_column_out, tone_single_out, receiver_sleep_out, osc_sleep_out});
            wr(1'b1, {3'b000, ~a0});
            repeat (2) @(negedge core_clk_in);
            check("ptr back", {~a0, i[1], 2'b00}, {tone_output_enable_out, receiver_sleep_out, 2'b00});
        end
        $display("test control fields done");
        rd_q.push_back(4'h0);
        rd_q.push_back(4'h0);
        u_dtx_host_model.soft_reset();
        @(negedge core_clk_in);
        check("soft reset", 4'h0, {tone_output_enable_out, tone_single_out, tone_column_out, receiver_sleep_out});
        $display("test soft reset done");
        // Receive: DTMF, interrupt on, receivers awake, then asleep
        d = 4'($urandom_range(0, 15));
        wr(1'b1, 4'hC);
        wr(1'b1, 4'h0);
        pulse(0, d);
        check("irq pin", 4'h0, {3'h0, interrupt_or_progress_pin_oe_b_out});
        rd(1'b1, 4'h5);
        rd(1'b0, d);
        rd(1'b1, 4'h0);
        pulse(2, 4'h0);
        rd(1'b1, 4'h8);
        pulse(1, 4'h0);
        rd(1'b1, 4'h0);
        wr(1'b1, 4'hC);
        wr(1'b1, 4'h2);
        pulse(0, d);
        rd(1'b1, 4'h0);
        $display("test receive done");
        // Burst, normal then call-progress timing
        for (int m = 0; m < 2; m++)
        begin
            wr(1'b1, m ? 4'hF : 4'hD);
            wr(1'b1, 4'h0);
            d = 4'($urandom_range(0, 15));
            tone_q.push_back(d);
            len_q.push_back(m ? 40 : 20);
            wr(1'b0, d);
            repeat (m ? 60 : 50) @(posedge core_clk_in);
            if (m == 0) check("irq pin", 4'h0, {3'h0, interrupt_or_progress_pin_oe_b_out});
            rd(1'b1, m ? 4'h0 : 4'h3);
            repeat (m ? 35 : 0) @(posedge core_clk_in);
            rd(1'b1, m ? 4'h3 : 4'h0);
        end
        $display("test burst done");
        // Fill the transmit buffer until it refuses, then let it drain
        wr(1'b1, 4'hD);
        wr(1'b1, 4'h0);
        for (int k = 0; k < 12; k++)
        begin
            d = 4'($urandom_range(0, 15));
            repeat (2) @(negedge core_clk_in);
            if (tx_data_ready_out === 1'b1)
            begin
                tone_q.push_back(d);
                len_q.push_back(20);
            end
            else
                refused++;
            wr(1'b0, d);
        end
        check("buffer refused", 4'h1, {3'h0, refused > 0});
        for (int w = 0; w < 700 && tone_q.size() > 0; w++) @(posedge core_clk_in);
        repeat (50) @(negedge core_clk_in);
        check("buffer drained", 4'h1, {3'h0, tx_data_ready_out});
        rd(1'b1, 4'h3);
        $display("test buffer done");
        // Untimed tone while enabled, stopped by clearing the enable
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h1);
        wr(1'b1, 4'h1);
        d = 4'($urandom_range(0, 15));
        len_q.push_back(0);
        wr(1'b0, d);
        repeat (70) @(negedge core_clk_in);
        check("untimed tone", 4'h1, {3'h0, tone_active_out});
        check("untimed digit", d, tone_digit_out);
        rd(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        repeat (2) @(negedge core_clk_in);
        check("tone stop", 4'h1, {2'h0, tone_active_out, tone_pin_oe_b_out});
        $display("test untimed tone done");
        repeat (5) @(posedge core_clk_in);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
